// [dtc_pkg.sv]
package dtc_pkg;

   // register bus geometry
   localparam int AXI_ADDR_W = 10;
   localparam int AXI_DATA_W = 32;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 8;
   localparam int BYTE_W = 8;
   localparam int LANE0 = 0;

   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_CTRL = 8'h88;
   localparam logic [7:0] IDX_MODE = 8'h89;
   localparam logic [7:0] IDX_T0_LOW = 8'h8a;
   localparam logic [7:0] IDX_T1_LOW = 8'h8b;
   localparam logic [7:0] IDX_T0_HIGH = 8'h8c;
   localparam logic [7:0] IDX_T1_HIGH = 8'h8d;

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // mode 0 prescaler width in the low byte
   localparam int PRESCALE_BITS = 5;

   typedef enum logic [1:0] {
      MODE_13BIT = 2'h0,
      MODE_16BIT = 2'h1,
      MODE_RELOAD = 2'h2,
      MODE_SPLIT = 2'h3
   } dtc_timer_mode_type;

   typedef struct packed {
      logic t1_overflow_flag;
      logic t1_run_bit;
      logic t0_overflow_flag;
      logic t0_run_bit;
      logic ext_irq1_flag;
      logic ext_irq1_trigger_type;
      logic ext_irq0_flag;
      logic ext_irq0_trigger_type;
   } dtc_control_type;

   typedef struct packed {
      logic gate;
      logic counter_sel;
      logic mode_select_high;
      logic mode_select_low;
   } dtc_mode_fields_type;

   typedef struct packed {
      dtc_mode_fields_type t1;
      dtc_mode_fields_type t0;
   } dtc_mode_reg_type;

   typedef enum logic [1:0] {
      WR_IDLE = 2'h1,
      WR_RESP = 2'h2
   } dtc_wr_state_type;

   localparam dtc_control_type CTRL_RESET = dtc_control_type'(8'h00);
   localparam dtc_mode_reg_type MODE_RESET = dtc_mode_reg_type'(8'h00);
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_ALL_ONES = 8'hff;

endpackage : dtc_pkg

// [dtc_timer_counter.sv]
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
module dtc_timer_counter #(
   parameter int MACHINE_CYCLE_CLOCKS = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [dtc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [dtc_pkg::AXI_DATA_W-1:0] s_axi_wdata,
   input wire logic [dtc_pkg::AXI_DATA_W/8-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [dtc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [dtc_pkg::AXI_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // external pins
   input wire logic ext_irq0_pin_n,
   input wire logic ext_irq1_pin_n,
   input wire logic t0_count_pin,
   input wire logic t1_count_pin,
   // vector acknowledges from the core
   input wire logic t0_vector_ack,
   input wire logic t1_vector_ack,
   input wire logic ext_irq0_vector_ack,
   input wire logic ext_irq1_vector_ack,
   // interrupt requests and baud tick
   output logic t0_overflow_flag,
   output logic t1_overflow_flag,
   output logic ext_irq0_flag,
   output logic ext_irq1_flag,
   output logic t1_baud_tick
);

   localparam int MC_W = (MACHINE_CYCLE_CLOCKS > 1) ? $clog2(MACHINE_CYCLE_CLOCKS) : 1;
   localparam logic [MC_W-1:0] MC_LAST = MC_W'(MACHINE_CYCLE_CLOCKS - 1);
   localparam int C13_W = dtc_pkg::BYTE_W + dtc_pkg::PRESCALE_BITS + 1;
   localparam int C16_W = 2 * dtc_pkg::BYTE_W + 1;
   localparam int C8_W = dtc_pkg::BYTE_W + 1;

   if (MACHINE_CYCLE_CLOCKS < 1 || MACHINE_CYCLE_CLOCKS > 256) begin : g_check
      $error("MACHINE_CYCLE_CLOCKS must lie in 1..256");
   end

   // {overflow, high, low} after one count step
   function automatic logic [C16_W-1:0] dtc_step(
      input dtc_pkg::dtc_timer_mode_type mode,
      input logic [dtc_pkg::BYTE_W-1:0] hi,
      input logic [dtc_pkg::BYTE_W-1:0] lo
   );
      logic [C13_W-1:0] c13;
      logic [C16_W-1:0] c16;
      logic [C8_W-1:0] c8;
      c13 = {1'b0, hi, lo[dtc_pkg::PRESCALE_BITS-1:0]} + C13_W'(1);
      c16 = {1'b0, hi, lo} + C16_W'(1);
      c8 = {1'b0, lo} + C8_W'(1);
      case (mode)
         dtc_pkg::MODE_13BIT: begin
            // upper low-byte bits are left alone; software must ignore them
            dtc_step = {c13[C13_W-1], c13[C13_W-2:dtc_pkg::PRESCALE_BITS],
                        lo[dtc_pkg::BYTE_W-1:dtc_pkg::PRESCALE_BITS],
                        c13[dtc_pkg::PRESCALE_BITS-1:0]};
         end
         dtc_pkg::MODE_16BIT: begin
            dtc_step = c16;
         end
         dtc_pkg::MODE_RELOAD: begin
            // reload from the high byte, which itself never changes
            dtc_step = {c8[C8_W-1], hi, c8[C8_W-1] ? hi : c8[C8_W-2:0]};
         end
         default: begin
            dtc_step = {c8[C8_W-1], hi, c8[C8_W-2:0]};
         end
      endcase
   endfunction : dtc_step

   function automatic dtc_pkg::dtc_timer_mode_type dtc_mode_of(
      input dtc_pkg::dtc_mode_fields_type f
   );
      dtc_mode_of = dtc_pkg::dtc_timer_mode_type'({f.mode_select_high, f.mode_select_low});
   endfunction : dtc_mode_of

   function automatic logic [dtc_pkg::IDX_W-1:0] dtc_index(
      input logic [dtc_pkg::AXI_ADDR_W-1:0] addr
   );
      dtc_index = addr[dtc_pkg::AXI_ADDR_W-1:dtc_pkg::IDX_LSB];
   endfunction : dtc_index

   function automatic logic dtc_mapped(input logic [dtc_pkg::AXI_ADDR_W-1:0] addr);
      logic [dtc_pkg::IDX_W-1:0] idx;
      idx = dtc_index(addr);
      dtc_mapped = (addr[dtc_pkg::IDX_LSB-1:0] == '0) &&
                   (idx >= dtc_pkg::IDX_CTRL) && (idx <= dtc_pkg::IDX_T1_HIGH);
   endfunction : dtc_mapped

   // registers
   dtc_pkg::dtc_control_type ctrl_reg;
   dtc_pkg::dtc_mode_reg_type mode_reg;
   logic [dtc_pkg::BYTE_W-1:0] t0_low_reg;
   logic [dtc_pkg::BYTE_W-1:0] t0_high_reg;
   logic [dtc_pkg::BYTE_W-1:0] t1_low_reg;
   logic [dtc_pkg::BYTE_W-1:0] t1_high_reg;
   logic [MC_W-1:0] mc_count_reg;
   logic ext0_prev_reg;
   logic ext1_prev_reg;
   logic t0_pin_prev_reg;
   logic t1_pin_prev_reg;
   logic baud_tick_reg;

   // bus slave state
   dtc_pkg::dtc_wr_state_type wr_state_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [dtc_pkg::AXI_ADDR_W-1:0] awaddr_reg;
   logic [dtc_pkg::AXI_DATA_W-1:0] wdata_reg;
   logic [dtc_pkg::AXI_DATA_W/8-1:0] wstrb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [dtc_pkg::AXI_DATA_W-1:0] rdata_reg;
   logic [1:0] rresp_reg;

   // write decode
   logic wr_fire;
   logic wr_ok;
   logic [dtc_pkg::IDX_W-1:0] wr_idx;
   logic [dtc_pkg::BYTE_W-1:0] wr_byte;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_t0_low;
   logic wr_t0_high;
   logic wr_t1_low;
   logic wr_t1_high;
   dtc_pkg::dtc_control_type wr_ctrl_val;

   assign wr_fire = (wr_state_reg == dtc_pkg::WR_IDLE) && aw_held_reg && w_held_reg;
   assign wr_ok = wr_fire && wstrb_reg[dtc_pkg::LANE0] && dtc_mapped(awaddr_reg);
   assign wr_idx = dtc_index(awaddr_reg);
   assign wr_byte = wdata_reg[dtc_pkg::BYTE_W-1:0];
   assign wr_ctrl_val = dtc_pkg::dtc_control_type'(wr_byte);
   assign wr_ctrl = wr_ok && (wr_idx == dtc_pkg::IDX_CTRL);
   assign wr_mode = wr_ok && (wr_idx == dtc_pkg::IDX_MODE);
   assign wr_t0_low = wr_ok && (wr_idx == dtc_pkg::IDX_T0_LOW);
   assign wr_t0_high = wr_ok && (wr_idx == dtc_pkg::IDX_T0_HIGH);
   assign wr_t1_low = wr_ok && (wr_idx == dtc_pkg::IDX_T1_LOW);
   assign wr_t1_high = wr_ok && (wr_idx == dtc_pkg::IDX_T1_HIGH);

   // count sources
   dtc_pkg::dtc_timer_mode_type t0_mode;
   dtc_pkg::dtc_timer_mode_type t1_mode;
   logic mc_tick;
   logic t0_pin_fall;
   logic t1_pin_fall;
   logic ext0_fall;
   logic ext1_fall;
   logic t0_src;
   logic t1_src;
   logic t0_en;
   logic t1_en;
   logic t0_split;
   logic t0_high_en;
   logic [C16_W-1:0] t0_step;
   logic [C16_W-1:0] t1_step;
   logic t0_ovf;
   logic t1_ovf;
   logic t0_high_ovf;
   logic tf0_set;
   logic tf1_set;

   assign t0_mode = dtc_mode_of(mode_reg.t0);
   assign t1_mode = dtc_mode_of(mode_reg.t1);
   assign t0_split = (t0_mode == dtc_pkg::MODE_SPLIT);
   assign mc_tick = (mc_count_reg == MC_LAST);
   assign t0_pin_fall = t0_pin_prev_reg && !t0_count_pin;
   assign t1_pin_fall = t1_pin_prev_reg && !t1_count_pin;
   assign ext0_fall = ext0_prev_reg && !ext_irq0_pin_n;
   assign ext1_fall = ext1_prev_reg && !ext_irq1_pin_n;
   assign t0_src = mode_reg.t0.counter_sel ? t0_pin_fall : mc_tick;
   assign t1_src = mode_reg.t1.counter_sel ? t1_pin_fall : mc_tick;
   // gate high lets the interrupt pin time a pulse width
   assign t0_en = ctrl_reg.t0_run_bit && (!mode_reg.t0.gate || ext_irq0_pin_n) && t0_src;
   // mode 3 on timer 1 acts as a cleared run bit
   assign t1_en = ctrl_reg.t1_run_bit && (!mode_reg.t1.gate || ext_irq1_pin_n) && t1_src &&
                  (t1_mode != dtc_pkg::MODE_SPLIT);
   // split high byte counts machine cycles on the timer 1 run bit
   assign t0_high_en = t0_split && ctrl_reg.t1_run_bit && mc_tick;
   assign t0_step = dtc_step(t0_mode, t0_high_reg, t0_low_reg);
   assign t1_step = dtc_step(t1_mode, t1_high_reg, t1_low_reg);
   assign t0_ovf = t0_step[C16_W-1];
   assign t1_ovf = t1_step[C16_W-1];
   assign t0_high_ovf = (t0_high_reg == dtc_pkg::COUNT_ALL_ONES);
   assign tf0_set = t0_en && t0_ovf;
   // while timer 0 is split the timer 1 flag belongs to its high byte
   assign tf1_set = t0_split ? (t0_high_en && t0_high_ovf) : (t1_en && t1_ovf);

   // machine-cycle divider
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mc_count_reg <= '0;
      end else if (mc_tick) begin
         mc_count_reg <= '0;
      end else begin
         mc_count_reg <= mc_count_reg + MC_W'(1);
      end
   end

   // pin history; cleared so a low pin at release is not an edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext0_prev_reg <= 1'b0;
         ext1_prev_reg <= 1'b0;
         t0_pin_prev_reg <= 1'b0;
         t1_pin_prev_reg <= 1'b0;
      end else begin
         ext0_prev_reg <= ext_irq0_pin_n;
         ext1_prev_reg <= ext_irq1_pin_n;
         t0_pin_prev_reg <= t0_count_pin;
         t1_pin_prev_reg <= t1_count_pin;
      end
   end

   // control and flags; a hardware set beats any clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= dtc_pkg::CTRL_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg.t1_run_bit <= wr_ctrl_val.t1_run_bit;
            ctrl_reg.t0_run_bit <= wr_ctrl_val.t0_run_bit;
            ctrl_reg.ext_irq1_trigger_type <= wr_ctrl_val.ext_irq1_trigger_type;
            ctrl_reg.ext_irq0_trigger_type <= wr_ctrl_val.ext_irq0_trigger_type;
         end
         if (tf1_set) begin
            ctrl_reg.t1_overflow_flag <= 1'b1;
         end else if (wr_ctrl) begin
            ctrl_reg.t1_overflow_flag <= wr_ctrl_val.t1_overflow_flag;
         end else if (t1_vector_ack) begin
            ctrl_reg.t1_overflow_flag <= 1'b0;
         end
         if (tf0_set) begin
            ctrl_reg.t0_overflow_flag <= 1'b1;
         end else if (wr_ctrl) begin
            ctrl_reg.t0_overflow_flag <= wr_ctrl_val.t0_overflow_flag;
         end else if (t0_vector_ack) begin
            ctrl_reg.t0_overflow_flag <= 1'b0;
         end
         // level mode: the source owns the flag, writes and acks do nothing
         if (!ctrl_reg.ext_irq1_trigger_type) begin
            ctrl_reg.ext_irq1_flag <= !ext_irq1_pin_n;
         end else if (ext1_fall) begin
            ctrl_reg.ext_irq1_flag <= 1'b1;
         end else if (wr_ctrl) begin
            ctrl_reg.ext_irq1_flag <= wr_ctrl_val.ext_irq1_flag;
         end else if (ext_irq1_vector_ack) begin
            ctrl_reg.ext_irq1_flag <= 1'b0;
         end
         if (!ctrl_reg.ext_irq0_trigger_type) begin
            ctrl_reg.ext_irq0_flag <= !ext_irq0_pin_n;
         end else if (ext0_fall) begin
            ctrl_reg.ext_irq0_flag <= 1'b1;
         end else if (wr_ctrl) begin
            ctrl_reg.ext_irq0_flag <= wr_ctrl_val.ext_irq0_flag;
         end else if (ext_irq0_vector_ack) begin
            ctrl_reg.ext_irq0_flag <= 1'b0;
         end
      end
   end

   // mode register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= dtc_pkg::MODE_RESET;
      end else if (wr_mode) begin
         mode_reg <= dtc_pkg::dtc_mode_reg_type'(wr_byte);
      end
   end

   // timer 0 bytes; a software write to a byte wins over its count step
   // run bit writes touch neither byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t0_low_reg <= dtc_pkg::COUNT_RESET;
         t0_high_reg <= dtc_pkg::COUNT_RESET;
      end else begin
         if (wr_t0_low) begin
            t0_low_reg <= wr_byte;
         end else if (t0_en) begin
            t0_low_reg <= t0_step[dtc_pkg::BYTE_W-1:0];
         end
         if (wr_t0_high) begin
            t0_high_reg <= wr_byte;
         end else if (t0_high_en) begin
            t0_high_reg <= t0_high_reg + dtc_pkg::BYTE_W'(1);
         end else if (t0_en && !t0_split) begin
            t0_high_reg <= t0_step[C16_W-2:dtc_pkg::BYTE_W];
         end
      end
   end

   // timer 1 bytes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t1_low_reg <= dtc_pkg::COUNT_RESET;
         t1_high_reg <= dtc_pkg::COUNT_RESET;
      end else begin
         if (wr_t1_low) begin
            t1_low_reg <= wr_byte;
         end else if (t1_en) begin
            t1_low_reg <= t1_step[dtc_pkg::BYTE_W-1:0];
         end
         if (wr_t1_high) begin
            t1_high_reg <= wr_byte;
         end else if (t1_en) begin
            t1_high_reg <= t1_step[C16_W-2:dtc_pkg::BYTE_W];
         end
      end
   end

   // baud tick keeps running from timer 1 even when it cannot raise its flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baud_tick_reg <= 1'b0;
      end else begin
         baud_tick_reg <= t1_en && t1_ovf;
      end
   end

   // write address channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         awready_reg <= 1'b0;
         awaddr_reg <= '0;
      end else if (wr_state_reg != dtc_pkg::WR_IDLE) begin
         aw_held_reg <= 1'b0;
         awready_reg <= 1'b0;
      end else if (awready_reg && s_axi_awvalid) begin
         aw_held_reg <= 1'b1;
         awready_reg <= 1'b0;
         awaddr_reg <= s_axi_awaddr;
      end else if (!aw_held_reg) begin
         awready_reg <= 1'b1;
      end
   end

   // write data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         wready_reg <= 1'b0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else if (wr_state_reg != dtc_pkg::WR_IDLE) begin
         w_held_reg <= 1'b0;
         wready_reg <= 1'b0;
      end else if (wready_reg && s_axi_wvalid) begin
         w_held_reg <= 1'b1;
         wready_reg <= 1'b0;
         wdata_reg <= s_axi_wdata;
         wstrb_reg <= s_axi_wstrb;
      end else if (!w_held_reg) begin
         wready_reg <= 1'b1;
      end
   end

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_reg <= dtc_pkg::WR_IDLE;
         bvalid_reg <= 1'b0;
         bresp_reg <= dtc_pkg::RESP_OKAY;
      end else begin
         case (wr_state_reg)
            dtc_pkg::WR_IDLE: begin
               if (wr_fire) begin
                  wr_state_reg <= dtc_pkg::WR_RESP;
                  bvalid_reg <= 1'b1;
                  bresp_reg <= dtc_mapped(awaddr_reg) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
               end
            end
            dtc_pkg::WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state_reg <= dtc_pkg::WR_IDLE;
                  bvalid_reg <= 1'b0;
               end
            end
            default: begin
               wr_state_reg <= dtc_pkg::WR_IDLE;
               bvalid_reg <= 1'b0;
            end
         endcase
      end
   end

   // read channel; reads have no side effects
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= dtc_pkg::RESP_OKAY;
      end else if (rvalid_reg) begin
         if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
         end
      end else if (arready_reg && s_axi_arvalid) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= dtc_mapped(s_axi_araddr) ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
         rdata_reg <= '0;
         case (dtc_index(s_axi_araddr))
            dtc_pkg::IDX_CTRL: rdata_reg[dtc_pkg::BYTE_W-1:0] <= ctrl_reg;
            dtc_pkg::IDX_MODE: rdata_reg[dtc_pkg::BYTE_W-1:0] <= mode_reg;
            dtc_pkg::IDX_T0_LOW: rdata_reg[dtc_pkg::BYTE_W-1:0] <= t0_low_reg;
            dtc_pkg::IDX_T1_LOW: rdata_reg[dtc_pkg::BYTE_W-1:0] <= t1_low_reg;
            dtc_pkg::IDX_T0_HIGH: rdata_reg[dtc_pkg::BYTE_W-1:0] <= t0_high_reg;
            dtc_pkg::IDX_T1_HIGH: rdata_reg[dtc_pkg::BYTE_W-1:0] <= t1_high_reg;
            default: rdata_reg <= '0;
         endcase
      end else begin
         arready_reg <= 1'b1;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign t0_overflow_flag = ctrl_reg.t0_overflow_flag;
   assign t1_overflow_flag = ctrl_reg.t1_overflow_flag;
   assign ext_irq0_flag = ctrl_reg.ext_irq0_flag;
   assign ext_irq1_flag = ctrl_reg.ext_irq1_flag;
   assign t1_baud_tick = baud_tick_reg;

endmodule : dtc_timer_counter

// [dtc_assertions.sv]
`timescale 1ns/1ns
module dtc_checker #(
   parameter int MACHINE_CYCLE_CLOCKS = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins, acks and flags
   input wire logic ext_irq0_pin_n,
   input wire logic ext_irq1_pin_n,
   input wire logic t0_vector_ack,
   input wire logic t1_vector_ack,
   input wire logic t0_overflow_flag,
   input wire logic t1_overflow_flag,
   input wire logic ext_irq0_flag,
   input wire logic ext_irq1_flag,
   input wire logic t1_baud_tick
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // a write lands one edge after its handshake; bvalid follows on that edge
   sequence s_wr_answer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   property p_reset_idle;
      $rose(aresetn) |-> !s_axi_bvalid && !t0_overflow_flag && !t1_overflow_flag
         ##1 s_axi_awready && s_axi_arready;
   endproperty
   property p_wr_resp;
      s_wr_taken |=> s_wr_answer;
   endproperty
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   property p_rd_release;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
   endproperty
   // write of the control register is the only other way to clear
   property p_t1_clr;
      $fell(t1_overflow_flag) |-> $past(t1_vector_ack) || $rose(s_axi_bvalid);
   endproperty
   property p_t0_clr;
      $fell(t0_overflow_flag) |-> $past(t0_vector_ack) || $rose(s_axi_bvalid);
   endproperty
   property p_irq1_set;
      $rose(ext_irq1_flag) |-> !$past(ext_irq1_pin_n) || $rose(s_axi_bvalid);
   endproperty
   property p_irq0_set;
      $rose(ext_irq0_flag) |-> !$past(ext_irq0_pin_n) || $rose(s_axi_bvalid);
   endproperty
   // only sound when a machine cycle spans more than one clock
   property p_baud;
      t1_baud_tick && MACHINE_CYCLE_CLOCKS > 1 |=> !t1_baud_tick;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("bad state after reset");
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");
   a_rd_resp: assert property (p_rd_resp) else $error("read response late");
   a_rd_release: assert property (p_rd_release) else $error("read not released");
   a_t1_clr: assert property (p_t1_clr) else $error("t1 flag cleared");
   a_t0_clr: assert property (p_t0_clr) else $error("t0 flag cleared");
   a_irq1_set: assert property (p_irq1_set) else $error("irq1 set");
   a_irq0_set: assert property (p_irq0_set) else $error("irq0 set");
   a_baud: assert property (p_baud) else $error("baud tick too long");
endmodule : dtc_checker

// [dtc_core_model.sv]
`timescale 1ns/1ns
module dtc_core_model (
   // clock
   input wire logic aclk,
   // bench controls
   input wire logic auto_ack,
   input wire logic [7:0] pulse_cnt,
   input wire logic pulse_go,
   // flags seen, acks and count pin driven
   input wire logic [3:0] flags,
   output logic [3:0] acks,
   output logic count_pin
);
   logic [8:0] left_reg = 9'h000;
   initial acks = 4'h0;
   initial count_pin = 1'b0;
   // pin rests low between bursts; one falling edge per two clocks
   always @(posedge aclk) begin
      if (pulse_go) left_reg <= {pulse_cnt, 1'b0};
      else if (left_reg != 9'h000) left_reg <= left_reg - 9'h001;
      count_pin <= left_reg[0];
      acks <= auto_ack ? flags & ~acks : 4'h0;
   end
endmodule : dtc_core_model

// [dtc_timer_counter_tb_top.sv]
`timescale 1ns/1ns
module dtc_timer_counter_tb_top;
   localparam logic [7:0] CT = dtc_pkg::IDX_CTRL;
   localparam logic [7:0] MD = dtc_pkg::IDX_MODE;
   localparam logic [7:0] L0 = dtc_pkg::IDX_T0_LOW;
   localparam logic [7:0] L1 = dtc_pkg::IDX_T1_LOW;
   localparam logic [7:0] H0 = dtc_pkg::IDX_T0_HIGH;
   localparam logic [7:0] H1 = dtc_pkg::IDX_T1_HIGH;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, irq0_n = 1'b1, irq1_n = 1'b1;
   logic auto_ack = 1'b0, pgo = 1'b0, awready, wready, bvalid, arready, rvalid, tick, cpin;
   logic [9:0] awaddr = 10'h000, araddr = 10'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp;
   logic [3:0] flags, acks;
   logic [7:0] pcnt = 8'h00, r;
   logic [33:0] q[$];
   logic [33:0] seen;
   int failures = 0, total_checks = 0, seed = 32'h203fc789;
   int ticks = 0;
   always #4 aclk = ~aclk;
   dtc_timer_counter #(.MACHINE_CYCLE_CLOCKS(3)) u_dtc_timer_counter (.aclk(aclk),
      .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_irq0_pin_n(irq0_n), .ext_irq1_pin_n(irq1_n), .t0_count_pin(cpin),
      .t1_count_pin(cpin), .t0_vector_ack(acks[0]), .t1_vector_ack(acks[1]),
      .ext_irq0_vector_ack(acks[2]), .ext_irq1_vector_ack(acks[3]),
      .t0_overflow_flag(flags[0]), .t1_overflow_flag(flags[1]), .ext_irq0_flag(flags[2]),
      .ext_irq1_flag(flags[3]), .t1_baud_tick(tick));
   dtc_core_model u_dtc_core_model (.aclk(aclk), .auto_ack(auto_ack), .pulse_cnt(pcnt),
      .pulse_go(pgo), .flags(flags), .acks(acks), .count_pin(cpin));
   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic complete_run;
      failures += q.size();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run
   // one transfer at a time; the expected answer is queued before the request goes out
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       input logic [1:0] rs);
      int n;
      n = 0;
      q.push_back({rs, 24'h0, w ? 8'h00 : d});
      awaddr <= {idx, 2'b00};
      araddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= w;
      wvalid <= w;
      bready <= w;
      arvalid <= !w;
      rready <= !w;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (arready) arvalid <= 1'b0;
      end while (!((bvalid && bready) || (rvalid && rready)) && n < 60);
      bready <= 1'b0;
      rready <= 1'b0;
      // one edge between transfers so no strobe is assigned twice in one step
      @(posedge aclk);
   endtask : xfer
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d, dtc_pkg::RESP_OKAY);
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b0, idx, d, dtc_pkg::RESP_OKAY);
   endtask : rd
   task automatic pulses(input logic [7:0] n);
      pcnt <= n;
      pgo <= 1'b1;
      @(posedge aclk);
      pgo <= 1'b0;
      repeat (2 * n + 4) @(posedge aclk);
   endtask : pulses
   task automatic ack;
      auto_ack <= 1'b1;
      repeat (4) @(posedge aclk);
      auto_ack <= 1'b0;
   endtask : ack
   always @(posedge aclk) begin
      if (tick) ticks++;
   end
   always @(posedge aclk) begin
      if ((bvalid && bready) || (rvalid && rready)) begin
         seen = (rvalid && rready) ? {rresp, rdata} : {bresp, 32'h0};
         if (q.size() == 0) failures++;
         else check(seen, q.pop_front());
      end
   end
   initial begin
      repeat (5000) @(posedge aclk);
      failures++;
      complete_run();
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (int i = 8'h88; i <= 8'h8d; i++) rd(i[7:0], 8'h00);
      xfer(1'b0, 8'h90, 8'h00, dtc_pkg::RESP_SLVERR);
      xfer(1'b1, 8'h90, 8'h5a, dtc_pkg::RESP_SLVERR);
      wr(MD, 8'h05);
      wr(L0, 8'hfe);
      wr(H0, 8'hff);
      wr(CT, 8'h10);
      pulses(3);
      rd(L0, 8'h01);
      rd(H0, 8'h00);
      rd(CT, 8'h30);
      ack();
      rd(CT, 8'h10);
      wr(CT, 8'h00);
      wr(MD, 8'h40);
      wr(L1, 8'he1);
      wr(H1, 8'hff);
      wr(CT, 8'h40);
      pulses(31);
      rd(L1, 8'he0);
      rd(H1, 8'h00);
      rd(CT, 8'hc0);
      check(ticks, 34'h1);
      rd(L0, 8'h01);
      ack();
      rd(CT, 8'h40);
      r = 8'($random(seed));
      wr(CT, 8'h00);
      wr(MD, 8'h06);
      wr(H0, r);
      wr(L0, 8'hfe);
      wr(CT, 8'h10);
      pulses(2);
      rd(L0, r);
      rd(H0, r);
      rd(CT, 8'h30);
      wr(CT, 8'h00);
      wr(MD, 8'h0d);
      wr(L0, 8'h00);
      wr(CT, 8'h10);
      irq0_n <= 1'b0;
      pulses(4);
      rd(L0, 8'h00);
      rd(CT, 8'h12);
      irq0_n <= 1'b1;
      pulses(4);
      rd(L0, 8'h04);
      rd(CT, 8'h10);
      wr(CT, 8'h05);
      irq0_n <= 1'b0;
      irq1_n <= 1'b0;
      repeat (3) @(posedge aclk);
      irq0_n <= 1'b1;
      irq1_n <= 1'b1;
      rd(CT, 8'h0f);
      ack();
      rd(CT, 8'h05);
      wr(CT, 8'h00);
      wr(MD, 8'h77);
      wr(H0, 8'hff);
      wr(CT, 8'h50);
      pulses(5);
      rd(L0, 8'h09);
      rd(L1, 8'he0);
      rd(CT, 8'hd0);
      complete_run();
   end
endmodule : dtc_timer_counter_tb_top
bind dtc_timer_counter dtc_checker #(.MACHINE_CYCLE_CLOCKS(MACHINE_CYCLE_CLOCKS)) u_dtc_checker (.*);
